// ---- core/fcw_top.sv ----
// Purpose: Fetch-count watchdog with keyed clear, APB register slave
// Assumes: FETCH, SLEEP and fuse inputs synchronous to SYS_CLK
// Notes: CPU_RESET is a one-cycle pulse per watchdog event
//
// Chosen here: the register addresses and register access over APB.
`include "fcw_cfg.svh"
`default_nettype none
module fcw_top
  import fcw_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic FETCH,
  input wire logic SLEEP,
  input wire logic FUSE_ENABLE_BIT,
  input wire logic [15:0] COUNT_MATCH_CFG_LOW,
  input wire logic [15:0] COUNT_MATCH_CFG_HIGH,
  input wire logic [15:0] WINDOW_CFG_LOW,
  input wire logic [15:0] WINDOW_CFG_HIGH,
  output logic CPU_RESET
);

  // Register state
  logic on_r, on_nxt; // Software enable
  logic [7:0] pre_r, pre_nxt; // Preclear key field
  logic [7:0] clr_r, clr_nxt; // Clear key field
  logic bad_preclear_flag_r, bad_preclear_flag_nxt; // Bad preclear flag
  logic bad_clear_flag_r, bad_clear_flag_nxt; // Bad clear flag
  logic evt_r, evt_nxt; // Timeout event flag
  logic [31:0] cnt_r, cnt_nxt; // Fetch counter
  logic [15:0] hold_r, hold_nxt; // Upper count snapshot
  logic rst_r, rst_nxt; // Processor reset pulse
  logic [31:0] prdata_r, prdata_nxt; // Read data
  logic pready_r, pready_nxt; // Access done
  logic pslverr_r, pslverr_nxt; // Unmapped access

  // Decode and derived terms
  fcw_sel_t sel; // Addressed register
  logic acc_first; // First access cycle, data latched
  logic wr; // Write commits this edge
  logic rd_lat; // Read data latched this edge
  logic enable; // Watchdog running
  logic [31:0] match_val; // Configured match count
  logic [31:0] win_val; // Configured window start
  logic match; // Count reached match value
  logic win_open; // Clear permitted now
  logic pre_wr, clr_wr; // Key register writes
  logic pre_bad; // Wrong preclear key written
  logic clr_ok; // Correct clear sequence
  logic clr_bad; // Wrong or early clear key
  logic evt_set; // New watchdog event
  logic cnt_step; // Counter advances this cycle
  logic [31:0] rdata; // Selected read word

  // Address decode; anything else answers with an error
  always_comb begin
    unique case (PADDR)
      `FCW_OFS_CTRL: sel = FCW_SEL_CTRL;
      `FCW_OFS_PRECLR: sel = FCW_SEL_PRECLR;
      `FCW_OFS_CLR: sel = FCW_SEL_CLR;
      `FCW_OFS_STAT: sel = FCW_SEL_STAT;
      `FCW_OFS_CNTL: sel = FCW_SEL_CNTL;
      `FCW_OFS_CNTH: sel = FCW_SEL_CNTH;
      `FCW_OFS_PSCNTL: sel = FCW_SEL_PSCNTL;
      `FCW_OFS_PSCNTH: sel = FCW_SEL_PSCNTH;
      `FCW_OFS_PSINTL: sel = FCW_SEL_PSINTL;
      `FCW_OFS_PSINTH: sel = FCW_SEL_PSINTH;
      `FCW_OFS_HOLD: sel = FCW_SEL_HOLD;
      default: sel = FCW_SEL_NONE;
    endcase
  end

  // Watchdog condition terms
  always_comb begin
    acc_first = PSEL & PENABLE & ~pready_r;
    wr = PSEL & PENABLE & pready_r & PWRITE;
    rd_lat = acc_first & ~PWRITE;
    // Fuse governs; software bit counts only with fuse clear
    enable = FUSE_ENABLE_BIT | on_r;
    match_val = {COUNT_MATCH_CFG_HIGH, COUNT_MATCH_CFG_LOW};
    win_val = {WINDOW_CFG_HIGH, WINDOW_CFG_LOW};
    match = enable & ~evt_r & (cnt_r == match_val);
    win_open = enable & (cnt_r >= win_val);
    pre_wr = wr & (sel == FCW_SEL_PRECLR);
    clr_wr = wr & (sel == FCW_SEL_CLR);
    pre_bad = pre_wr &
      (PWDATA[`FCW_PRE_HI:`FCW_PRE_LO] != `FCW_PRE_KEY);
    // Clear needs the preclear key in place and an open window
    clr_ok = clr_wr & win_open & (pre_r == `FCW_PRE_KEY) &
      (PWDATA[`FCW_CLR_HI:`FCW_CLR_LO] == `FCW_CLR_KEY);
    clr_bad = clr_wr & ~clr_ok;
    // Only the first cause raises an event; later ones are masked
    evt_set = ~evt_r & (match | pre_bad | clr_bad);
    // Fetches stop in Sleep, so the count freezes there
    cnt_step = enable & FETCH & ~SLEEP & ~evt_r & ~match;
  end

  // Read multiplexer; unused bits stay zero
  always_comb begin
    rdata = `FCW_RST_WORD;
    unique case (sel)
      FCW_SEL_CTRL: rdata[`FCW_ON_BIT] = on_r;
      FCW_SEL_PRECLR: rdata[`FCW_PRE_HI:`FCW_PRE_LO] = pre_r;
      FCW_SEL_CLR: rdata[`FCW_CLR_HI:`FCW_CLR_LO] = clr_r;
      // Window bit is live, not latched, so it tracks the counter
      FCW_SEL_STAT: begin
        rdata[`FCW_BAD_PRECLEAR_FLAG_BIT] = bad_preclear_flag_r;
        rdata[`FCW_BAD_CLEAR_FLAG_BIT] = bad_clear_flag_r;
        rdata[`FCW_EVT_BIT] = evt_r;
        rdata[`FCW_WIN_BIT] = win_open;
      end
      FCW_SEL_CNTL: rdata[15:0] = cnt_r[15:0];
      FCW_SEL_CNTH: rdata[15:0] = cnt_r[31:16];
      FCW_SEL_PSCNTL: rdata[15:0] = COUNT_MATCH_CFG_LOW;
      FCW_SEL_PSCNTH: rdata[15:0] = COUNT_MATCH_CFG_HIGH;
      FCW_SEL_PSINTL: rdata[15:0] = WINDOW_CFG_LOW;
      FCW_SEL_PSINTH: rdata[15:0] = WINDOW_CFG_HIGH;
      FCW_SEL_HOLD: rdata[15:0] = hold_r;
      FCW_SEL_NONE: rdata = `FCW_RST_WORD;
    endcase
  end

  // Next-state logic for the watchdog and the bus answer
  always_comb begin
    on_nxt = on_r;
    pre_nxt = pre_r;
    clr_nxt = clr_r;
    bad_preclear_flag_nxt = bad_preclear_flag_r;
    bad_clear_flag_nxt = bad_clear_flag_r;
    evt_nxt = evt_r | evt_set;
    cnt_nxt = cnt_r;
    hold_nxt = hold_r;
    rst_nxt = evt_set;
    // One wait state: the answer follows the first access edge
    pready_nxt = acc_first;
    pslverr_nxt = acc_first & (sel == FCW_SEL_NONE);
    prdata_nxt = prdata_r;
    if (cnt_step) begin
      cnt_nxt = cnt_r + 32'h0000_0001;
    end
    // Reset action one cycle after the event; the event flag stays
    if (rst_r) begin
      pre_nxt = `FCW_RST_KEY;
      clr_nxt = `FCW_RST_KEY;
      bad_preclear_flag_nxt = 1'b0;
      bad_clear_flag_nxt = 1'b0;
      cnt_nxt = `FCW_RST_CNT;
    end
    // Writes come after the reset action so a new set wins
    if (wr & (sel == FCW_SEL_CTRL)) begin
      on_nxt = PWDATA[`FCW_ON_BIT];
    end
    if (pre_wr) begin
      pre_nxt = PWDATA[`FCW_PRE_HI:`FCW_PRE_LO];
      if (pre_bad) begin
        bad_preclear_flag_nxt = 1'b1;
      end
    end
    if (clr_ok) begin
      // Good sequence: both keys and the count go back to zero
      pre_nxt = `FCW_RST_KEY;
      clr_nxt = `FCW_RST_KEY;
      cnt_nxt = `FCW_RST_CNT;
    end else if (clr_bad) begin
      clr_nxt = PWDATA[`FCW_CLR_HI:`FCW_CLR_LO];
      bad_clear_flag_nxt = 1'b1;
    end
    if (acc_first) begin
      prdata_nxt = PWRITE ? `FCW_RST_WORD : rdata;
    end
    // Snapshot the high half in the same cycle the count is latched
    if (rd_lat & ((sel == FCW_SEL_CNTL) | (sel == FCW_SEL_CNTH))) begin
      hold_nxt = cnt_r[31:16];
    end
  end

  // All state on the one system clock, synchronous reset
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      // Power-on values; the event flag only clears here
      on_r <= 1'b0;
      pre_r <= `FCW_RST_KEY;
      clr_r <= `FCW_RST_KEY;
      bad_preclear_flag_r <= 1'b0;
      bad_clear_flag_r <= 1'b0;
      evt_r <= 1'b0;
      cnt_r <= `FCW_RST_CNT;
      hold_r <= `FCW_RST_HOLD;
      rst_r <= 1'b0;
      prdata_r <= `FCW_RST_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      on_r <= on_nxt;
      pre_r <= pre_nxt;
      clr_r <= clr_nxt;
      bad_preclear_flag_r <= bad_preclear_flag_nxt;
      bad_clear_flag_r <= bad_clear_flag_nxt;
      evt_r <= evt_nxt;
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
      rst_r <= rst_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign CPU_RESET = rst_r;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  // Match raises the event and the reset pulse together
  match_reset_a: assert property (
    match |=> evt_r && CPU_RESET ##1 !CPU_RESET && cnt_r == 32'h0)
    else $error("count match did not reset processor");

  // Counter steps by exactly one per fetch
  count_step_a: assert property (
    cnt_step && !rst_r && !clr_ok |=> cnt_r == $past(cnt_r) + 32'h1)
    else $error("counter did not advance on fetch");

  // Sleep freezes the count
  sleep_hold_a: assert property (
    SLEEP && !rst_r && !clr_ok |=> $stable(cnt_r))
    else $error("counter moved during sleep");

  // Disabled watchdog never counts
  sw_enable_a: assert property (
    !FUSE_ENABLE_BIT && !on_r && !rst_r && !clr_ok |=> $stable(cnt_r))
    else $error("counter moved while disabled");

  // Good clear zeroes keys and counter
  good_clear_a: assert property (
    clr_ok |=> cnt_r == 32'h0 && pre_r == 8'h00 && clr_r == 8'h00)
    else $error("clear sequence did not reset counter");

  // Bad clear captures value and keeps preclear key
  bad_clear_a: assert property (
    clr_bad && !rst_r |=> bad_clear_flag_r && evt_r && pre_r == $past(pre_r) &&
      clr_r == $past(PWDATA[7:0]))
    else $error("bad clear key handled wrongly");

  // Bad preclear flags and raises the event
  bad_preclear_a: assert property (
    pre_bad |=> bad_preclear_flag_r && evt_r)
    else $error("bad preclear key not flagged");

  // Reset action wipes key fields and the bad preclear flag
  reset_keys_a: assert property (
    rst_r && !wr |=> pre_r == 8'h00 && clr_r == 8'h00 && !bad_preclear_flag_r)
    else $error("watchdog reset left key fields set");

  // Hold only changes on a latched count read
  hold_load_a: assert property (
    !(rd_lat && (sel == FCW_SEL_CNTL || sel == FCW_SEL_CNTH))
      |=> $stable(hold_r))
    else $error("hold register changed without count read");

  // Status read shows window flag and zero upper bits
  stat_read_a: assert property (
    rd_lat && sel == FCW_SEL_STAT |=>
      PRDATA[0] == $past(win_open) && PRDATA[31:8] == 24'h0)
    else $error("status read wrong");

  // Snapshot equals the high half at the latching edge
  hold_snap_a: assert property (
    rd_lat && (sel == FCW_SEL_CNTL || sel == FCW_SEL_CNTH) |=>
      hold_r == $past(cnt_r[31:16]))
    else $error("hold register missed the high count");

  // A preclear write always stores its byte, good or bad
  pre_store_a: assert property (
    pre_wr |=> pre_r == $past(PWDATA[`FCW_PRE_HI:`FCW_PRE_LO]))
    else $error("preclear key not stored");

  // Every new event shows in the flag and on the reset pin
  event_pulse_a: assert property (
    evt_set |=> evt_r && CPU_RESET)
    else $error("event did not raise flag and reset");

  // Event flag is sticky until the system reset
  event_sticky_a: assert property (
    evt_r |=> evt_r)
    else $error("event flag dropped");

  // Reset pin is a single-cycle pulse
  reset_pulse_a: assert property (
    CPU_RESET |=> !CPU_RESET)
    else $error("processor reset wider than one cycle");

  // Unmapped access answers with an error and zero data
  unmapped_access_a: assert property (
    acc_first && sel == FCW_SEL_NONE |=>
      PREADY && PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access answered wrongly");

  // Count match mirror reads the configuration word
  mirror_read_a: assert property (
    rd_lat && sel == FCW_SEL_PSCNTL |=>
      PRDATA == {16'h0000, $past(COUNT_MATCH_CFG_LOW)})
    else $error("count mirror read wrong");

  // Low count register reads the live counter
  count_read_a: assert property (
    rd_lat && sel == FCW_SEL_CNTL |=>
      PRDATA == {16'h0000, $past(cnt_r[15:0])})
    else $error("count low read wrong");

endmodule
`default_nettype wire

// ---- core/fcw_cfg.svh ----
// Purpose: Register offsets, field positions, keys and reset values
// Assumes: 32-bit APB data, each register one aligned word
// Notes: Definitions only
`ifndef FCW_CFG_SVH
`define FCW_CFG_SVH

// Byte offsets of the registers
`define FCW_OFS_CTRL 8'h00
`define FCW_OFS_PRECLR 8'h04
`define FCW_OFS_CLR 8'h08
`define FCW_OFS_STAT 8'h0C
`define FCW_OFS_CNTL 8'h10
`define FCW_OFS_CNTH 8'h14
`define FCW_OFS_PSCNTL 8'h18
`define FCW_OFS_PSCNTH 8'h1C
`define FCW_OFS_PSINTL 8'h20
`define FCW_OFS_PSINTH 8'h24
`define FCW_OFS_HOLD 8'h28

// Field positions
`define FCW_ON_BIT 15
`define FCW_PRE_HI 15
`define FCW_PRE_LO 8
`define FCW_CLR_HI 7
`define FCW_CLR_LO 0
`define FCW_BAD_PRECLEAR_FLAG_BIT 7
`define FCW_BAD_CLEAR_FLAG_BIT 6
`define FCW_EVT_BIT 5
`define FCW_WIN_BIT 0

// Key values
`define FCW_PRE_KEY 8'h40
`define FCW_CLR_KEY 8'h08

// Reset values
`define FCW_RST_KEY 8'h00
`define FCW_RST_CNT 32'h0000_0000
`define FCW_RST_HOLD 16'h0000
`define FCW_RST_WORD 32'h0000_0000

`endif

// ---- core/fcw_pkg.sv ----
// Purpose: Types shared by the fetch watchdog
// Assumes: Offsets come from fcw_cfg.svh
// Notes: Register select enumeration only
`default_nettype none
package fcw_pkg;
  // Which register an APB address selects
  typedef enum {
    FCW_SEL_CTRL, FCW_SEL_PRECLR, FCW_SEL_CLR, FCW_SEL_STAT,
    FCW_SEL_CNTL, FCW_SEL_CNTH, FCW_SEL_PSCNTL, FCW_SEL_PSCNTH,
    FCW_SEL_PSINTL, FCW_SEL_PSINTH, FCW_SEL_HOLD, FCW_SEL_NONE
  } fcw_sel_t;
endpackage
`default_nettype wire

// ---- bench/fetch_count_watchdog_bench.sv ----
// Purpose: Self-checking bench for the fetch-count watchdog
// Assumes: APB slave answers after one wait state
// Notes: One long count run crosses into the upper half
`include "fcw_cfg.svh"
`default_nettype none
module fetch_count_watchdog_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0; // System clock
  logic srst = 1; // Sync reset
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_reset;
  logic fetch = 0, sleep = 0, fuse = 0; // Core side stimulus
  logic [15:0] mlo = 16'h0000, mhi = 16'h0002; // Match far away
  logic [15:0] wlo = 16'h0000, whi = 16'h0000; // Window open at 0
  logic err_seen; // Error flag of last transfer
  logic [31:0] v;
  int n_fail = 0, cmp_count = 0, n_rst = 0;

  fcw_top dut (.SYS_CLK(clk), .SRST(srst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FETCH(fetch), .SLEEP(sleep),
    .FUSE_ENABLE_BIT(fuse), .COUNT_MATCH_CFG_LOW(mlo),
    .COUNT_MATCH_CFG_HIGH(mhi), .WINDOW_CFG_LOW(wlo),
    .WINDOW_CFG_HIGH(whi), .CPU_RESET(cpu_reset));

  // 50 ns period
  initial begin
    forever #25 clk = ~clk;
  end

  // Count reset pulses mid-cycle, where the pin has settled, so a
  // check right after a rising edge already sees the new count
  always @(negedge clk) begin
    if (cpu_reset === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      final_report();
    end
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    apb(1'b1, a, d, t);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] t;
    apb(1'b0, a, 32'h0000_0000, t);
    chk(t, e);
  endtask

  // Exactly n sampled edges with a fetch
  task automatic pulse_fetch(input int n);
    fetch <= 1'b1;
    repeat (n) @(posedge clk);
    fetch <= 1'b0;
  endtask

  task automatic do_reset();
    srst <= 1'b1;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask

  initial begin
    int i;
    mlo <= 16'h1234;
    do_reset();
    rc(`FCW_OFS_CTRL, 32'h0000_0000);
    rc(`FCW_OFS_HOLD, 32'h0000_0000);
    rc(`FCW_OFS_STAT, 32'h0000_0000);
    rc(`FCW_OFS_PSCNTL, 32'h0000_1234);
    rc(`FCW_OFS_PSCNTH, 32'h0000_0002);
    whi <= 16'hA5C3;
    rc(`FCW_OFS_PSINTH, 32'h0000_A5C3);
    rc(`FCW_OFS_PSINTL, 32'h0000_0000);
    whi <= 16'h0000;
    rc(8'h30, 32'h0000_0000);
    chk({31'h0, err_seen}, 32'h1);
    // Disabled: fetches must not count
    pulse_fetch(5);
    rc(`FCW_OFS_CNTL, 32'h0000_0000);
    wr(`FCW_OFS_CTRL, 32'hFFFF_FFFF);
    rc(`FCW_OFS_CTRL, 32'h0000_8000);
    sleep <= 1'b1;
    pulse_fetch(4);
    sleep <= 1'b0;
    rc(`FCW_OFS_CNTL, 32'h0000_0000);
    pulse_fetch(7);
    rc(`FCW_OFS_CNTL, 32'h0000_0007);
    rc(`FCW_OFS_STAT, 32'h0000_0001);
    // Cross into the upper half
    pulse_fetch(65536);
    rc(`FCW_OFS_CNTH, 32'h0000_0001);
    rc(`FCW_OFS_HOLD, 32'h0000_0001);
    wr(`FCW_OFS_PRECLR, 32'h0000_4000);
    rc(`FCW_OFS_PRECLR, 32'h0000_4000);
    wr(`FCW_OFS_CLR, 32'h0000_0008);
    rc(`FCW_OFS_HOLD, 32'h0000_0001);
    rc(`FCW_OFS_CNTH, 32'h0000_0000);
    rc(`FCW_OFS_CNTL, 32'h0000_0000);
    rc(`FCW_OFS_PRECLR, 32'h0000_0000);
    chk(n_rst, 0);
    wlo <= 16'h0100;
    rc(`FCW_OFS_STAT, 32'h0000_0000);
    wlo <= 16'h0000;
    // Wrong clear key without preclear
    wr(`FCW_OFS_CLR, 32'h0000_0055);
    chk(n_rst, 1);
    apb(1'b0, `FCW_OFS_STAT, 32'h0, v);
    chk(v & 32'h20, 32'h20);
    rc(`FCW_OFS_CLR, 32'h0000_0000);
    // Wrong preclear key
    do_reset();
    wr(`FCW_OFS_CTRL, 32'h0000_8000);
    wr(`FCW_OFS_PRECLR, 32'h0000_1200);
    chk(n_rst, 2);
    rc(`FCW_OFS_PRECLR, 32'h0000_0000);
    // Fuse enable with control off, small match
    do_reset();
    fuse <= 1'b1;
    mlo <= 16'h000A;
    mhi <= 16'h0000;
    fetch <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (cpu_reset === 1'b1) break;
    end
    if (i == 100) begin
      n_fail++;
      final_report();
    end
    fetch <= 1'b0;
    chk(n_rst, 3);
    rc(`FCW_OFS_CNTL, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
